// File: logic/frame_request_exposure_readout.sv
// frame sequencer, exposure timing and lane serialiser
`timescale 1ns/1ps
module frame_request_exposure_readout (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    frame_req_pin,
  input  wire logic                    external_exposure_in,
  input  wire logic                    master_clk_pin,
  input  wire sensor_pkg::cfg_t        cfg_in,
  input  wire logic                    cfg_write,
  input  wire logic                    pix_in_valid,
  input  wire sensor_pkg::pix_bundle_t pix_in_data,
  output logic                         pix_in_ready,
  output sensor_pkg::lvds_t            lvds_out,
  output logic                         busy
);

  // ***************************************************************
  // pin synchronisers and edge detection
  // ***************************************************************
  logic [2:0] s0_reg, s0_next, s1_reg, s1_next, s2_reg, s2_next;
  logic       tick, req_rise, exp_rise;

  always_comb begin
    s0_next  = {master_clk_pin, external_exposure_in, frame_req_pin};
    s1_next  = s0_reg;
    s2_next  = s1_reg;
    tick     = s1_reg[2] & ~s2_reg[2];
    exp_rise = s1_reg[1] & ~s2_reg[1];
    req_rise = s1_reg[0] & ~s2_reg[0];
  end

  always_ff @(posedge clk or posedge rst) begin // [R25]
    if (rst) begin
      s0_reg <= 3'h0;
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
    end else begin
      s0_reg <= s0_next;
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end

  // ***************************************************************
  // configuration
  // ***************************************************************
  sensor_pkg::cfg_t cfg_reg, cfg_next;
  logic [1:0]       eff_mode;
  logic [3:0]       n_bursts, width;
  logic [15:0]      fot_total;
  logic [23:0]      ro_total;

  always_comb begin
    cfg_next = cfg_write ? cfg_in : cfg_reg;
    // 12-bit conversion is slow, so lanes are folded to four or two
    if (cfg_reg.bits12) begin // [R22]
      eff_mode = cfg_reg.two_lane ? 2'h3 : 2'h2;
    end else begin
      eff_mode = cfg_reg.lane_mode;
    end
    n_bursts  = 4'h1 << eff_mode; // [R20] [R21]
    width     = cfg_reg.bits12 ? sensor_pkg::BITS_WIDE
                               : sensor_pkg::BITS_NARROW;
    fot_total = 16'(({8'h0, cfg_reg.fot_len} + {11'h0, n_bursts, 1'b0})
                    * {8'h0, sensor_pkg::FOT_UNIT});
    ro_total  = 24'({13'h0, cfg_reg.rows} * {20'h0, n_bursts}
                    * ({16'h0, sensor_pkg::BURST_LEN} + 24'h1));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= sensor_pkg::CFG_RST; // [R1] [R23]
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ***************************************************************
  // exposure sequencer
  // ***************************************************************
  sensor_pkg::expo_state_t e_state_reg, e_state_next;
  sensor_pkg::read_state_t r_state_reg, r_state_next;
  logic [23:0] e_cnt_reg, e_cnt_next, ro_left_reg, ro_left_next;
  logic [15:0] frames_reg, frames_next;
  logic        first_reg, first_next;
  logic        abort_ok, handoff;

  always_comb begin
    e_state_next = e_state_reg;
    e_cnt_next   = e_cnt_reg;
    frames_next  = frames_reg;
    first_next   = first_reg;
    // a fresh request in the earlier revision may cut a readout short
    abort_ok = !cfg_reg.later_rev && first_reg && !cfg_reg.ext_exp
               && r_state_reg == sensor_pkg::R_READ; // [R9]
    handoff  = e_state_reg == sensor_pkg::E_DONE
               && (r_state_reg == sensor_pkg::R_IDLE || abort_ok); // [R6]
    case (e_state_reg)
      sensor_pkg::E_IDLE: begin
        if (cfg_reg.ext_exp) begin
          if (exp_rise) begin // [R11] [R13]
            e_state_next = sensor_pkg::E_EXPOSE;
            first_next   = 1'b1;
          end
        end else if (req_rise) begin // [R1]
          frames_next = cfg_reg.frame_count;
          first_next  = 1'b1;
          e_cnt_next  = {16'h0, sensor_pkg::EXP_START_DELAY};
          if (cfg_reg.later_rev && r_state_reg == sensor_pkg::R_READ) begin
            e_state_next = sensor_pkg::E_PEND; // [R8]
          end else begin
            e_state_next = sensor_pkg::E_DELAY; // [R2]
          end
        end
      end
      sensor_pkg::E_PEND: begin
        // hold back so the overhead lands on the end of the readout
        if (r_state_reg != sensor_pkg::R_READ
            || ro_left_reg <= cfg_reg.exp_time
               + {16'h0, sensor_pkg::EXP_START_DELAY}) begin // [R8]
          e_state_next = sensor_pkg::E_DELAY;
        end
      end
      sensor_pkg::E_DELAY: begin
        if (tick) begin // [R2]
          e_cnt_next = e_cnt_reg - 24'h1;
          if (e_cnt_reg <= 24'h1) begin
            e_state_next = sensor_pkg::E_EXPOSE;
            e_cnt_next   = cfg_reg.exp_time; // [R3]
          end
        end
      end
      sensor_pkg::E_EXPOSE: begin
        if (cfg_reg.ext_exp) begin
          if (req_rise) begin // [R11]
            e_state_next = sensor_pkg::E_DONE;
          end
        end else if (tick) begin // [R3]
          e_cnt_next = e_cnt_reg - 24'h1;
          if (e_cnt_reg <= 24'h1) begin
            e_state_next = sensor_pkg::E_DONE;
          end
        end
      end
      sensor_pkg::E_DONE: begin
        if (handoff) begin // [R4]
          first_next = 1'b0;
          if (!cfg_reg.ext_exp && frames_reg > 16'h1) begin // [R5]
            frames_next  = frames_reg - 16'h1;
            e_cnt_next   = cfg_reg.exp_time;
            e_state_next = sensor_pkg::E_EXPOSE;
          end else begin
            frames_next  = 16'h0;
            e_state_next = sensor_pkg::E_IDLE;
          end
        end
      end
      default: e_state_next = sensor_pkg::E_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      e_state_reg <= sensor_pkg::E_IDLE;
      e_cnt_reg   <= 24'h0;
      frames_reg  <= 16'h0;
      first_reg   <= 1'b0;
    end else begin
      e_state_reg <= e_state_next;
      e_cnt_reg   <= e_cnt_next;
      frames_reg  <= frames_next;
      first_reg   <= first_next;
    end
  end

  // ***************************************************************
  // overhead and readout sequencer
  // ***************************************************************
  logic [15:0] fot_cnt_reg, fot_cnt_next;
  logic [7:0]  pix_reg, pix_next;
  logic [3:0]  burst_reg, burst_next;
  logic [10:0] row_reg, row_next;

  always_comb begin
    r_state_next = r_state_reg;
    fot_cnt_next = fot_cnt_reg;
    pix_next     = pix_reg;
    burst_next   = burst_reg;
    row_next     = row_reg;
    ro_left_next = ro_left_reg;
    if (handoff) begin // [R4] [R9]
      r_state_next = sensor_pkg::R_FOT;
      fot_cnt_next = fot_total;
    end else begin
      case (r_state_reg)
        sensor_pkg::R_FOT: begin
          if (tick) begin
            fot_cnt_next = fot_cnt_reg - 16'h1;
            if (fot_cnt_reg <= 16'h1) begin // [R4]
              r_state_next = sensor_pkg::R_READ;
              pix_next     = 8'h0;
              burst_next   = 4'h0;
              row_next     = 11'h0;
              ro_left_next = ro_total;
            end
          end
        end
        sensor_pkg::R_READ: begin
          if (tick) begin
            ro_left_next = ro_left_reg - 24'h1;
            pix_next     = pix_reg + 8'h1;
            if (pix_reg == sensor_pkg::BURST_LEN) begin // [R19]
              pix_next   = 8'h0;
              burst_next = burst_reg + 4'h1;
              if (burst_reg == n_bursts - 4'h1) begin // [R21]
                burst_next = 4'h0;
                row_next   = row_reg + 11'h1;
                if (row_reg == cfg_reg.rows - 11'h1) begin
                  r_state_next = sensor_pkg::R_IDLE;
                end
              end
            end
          end
        end
        default: r_state_next = sensor_pkg::R_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_state_reg <= sensor_pkg::R_IDLE;
      fot_cnt_reg <= 16'h0;
      pix_reg     <= 8'h0;
      burst_reg   <= 4'h0;
      row_reg     <= 11'h0;
      ro_left_reg <= 24'h0;
    end else begin
      r_state_reg <= r_state_next;
      fot_cnt_reg <= fot_cnt_next;
      pix_reg     <= pix_next;
      burst_reg   <= burst_next;
      row_reg     <= row_next;
      ro_left_reg <= ro_left_next;
    end
  end

  // ***************************************************************
  // pixel buffer
  // ***************************************************************
  sensor_pkg::pix_bundle_t fifo_data;
  logic                    fifo_valid, fifo_pop, in_burst, pix_valid;

  // an empty buffer drops the pixel valid flag instead of stalling
  assign in_burst  = r_state_reg == sensor_pkg::R_READ
                     && pix_reg < sensor_pkg::BURST_LEN;
  assign pix_valid = in_burst & fifo_valid;
  assign fifo_pop  = tick & in_burst;

  pixel_fifo #(
    .WIDTH ($bits(sensor_pkg::pix_bundle_t)),
    .DEPTH (sensor_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (pix_in_valid),
    .in_ready  (pix_in_ready),
    .in_data   (pix_in_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // ***************************************************************
  // lane words and control word
  // ***************************************************************
  logic [sensor_pkg::LANES:0][sensor_pkg::WORD_MAX-1:0] word;
  logic [sensor_pkg::WORD_MAX-1:0] mask;
  logic                            inte;

  assign mask = cfg_reg.bits12 ? 12'hFFF : 12'h3FF;
  assign inte = e_state_reg == sensor_pkg::E_EXPOSE
                && r_state_reg != sensor_pkg::R_FOT;

  for (genvar i = 0; i < sensor_pkg::LANES; i++) begin : g_lane
    // folded modes drive only every n-th lane; the rest idle at zero
    assign word[i] = (pix_valid && (4'(i) & (n_bursts - 4'h1)) == 4'h0)
                     ? fifo_data.word[i] & mask : 12'h0; // [R26]
  end

  always_comb begin
    word[sensor_pkg::LANES] = 12'h0; // [R16]
    word[sensor_pkg::LANES][sensor_pkg::CTL_PIXEL_VALID] =
      pix_valid; // [R24]
    word[sensor_pkg::LANES][sensor_pkg::CTL_ROW_VALID] =
      r_state_reg == sensor_pkg::R_READ;
    word[sensor_pkg::LANES][sensor_pkg::CTL_FRAME_VALID] =
      r_state_reg == sensor_pkg::R_READ;
    word[sensor_pkg::LANES][sensor_pkg::CTL_SLOT] =
      r_state_reg == sensor_pkg::R_READ && !in_burst;
    word[sensor_pkg::LANES][sensor_pkg::CTL_FOT]  =
      r_state_reg == sensor_pkg::R_FOT;
    word[sensor_pkg::LANES][sensor_pkg::CTL_INTE] = inte;
    word[sensor_pkg::LANES][sensor_pkg::CTL_ONE]  = 1'b1;
  end

  // ***************************************************************
  // serialiser
  // ***************************************************************
  // one bit per clk; the master period must be at least 12 clk cycles
  logic [sensor_pkg::LANES:0][sensor_pkg::WORD_MAX-1:0] sh_reg, sh_next;
  logic [3:0]        bit_cnt_reg, bit_cnt_next;
  sensor_pkg::lvds_t lvds_reg, lvds_next;
  logic              busy_reg, busy_next;

  always_comb begin
    sh_next      = sh_reg;
    bit_cnt_next = bit_cnt_reg;
    lvds_next    = '0;
    busy_next    = e_state_reg != sensor_pkg::E_IDLE
                   || r_state_reg != sensor_pkg::R_IDLE;
    for (int k = 0; k <= sensor_pkg::LANES; k++) begin
      if (tick) begin // [R14] [R17]
        sh_next[k] = word[k] >> 1;
      end else if (bit_cnt_reg != 4'h0) begin
        sh_next[k] = sh_reg[k] >> 1;
      end
    end
    if (tick) begin // [R18]
      lvds_next.lanes = {word[15][0], word[14][0], word[13][0], word[12][0],
                         word[11][0], word[10][0], word[9][0], word[8][0],
                         word[7][0], word[6][0], word[5][0], word[4][0],
                         word[3][0], word[2][0], word[1][0], word[0][0]};
      lvds_next.ctrl                = word[sensor_pkg::LANES][0];
      lvds_next.forwarded_ddr_clock = 1'b1; // [R17]
      bit_cnt_next                  = width - 4'h1;
    end else if (bit_cnt_reg != 4'h0) begin
      for (int k = 0; k < sensor_pkg::LANES; k++) begin
        lvds_next.lanes[k] = sh_reg[k][0];
      end
      lvds_next.ctrl                = sh_reg[sensor_pkg::LANES][0];
      lvds_next.forwarded_ddr_clock = ~lvds_reg.forwarded_ddr_clock; // [R15]
      bit_cnt_next                  = bit_cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_reg      <= '0;
      bit_cnt_reg <= 4'h0;
      lvds_reg    <= '0;
      busy_reg    <= 1'b0;
    end else begin
      sh_reg      <= sh_next;
      bit_cnt_reg <= bit_cnt_next;
      lvds_reg    <= lvds_next;
      busy_reg    <= busy_next;
    end
  end

  assign lvds_out = lvds_reg;
  assign busy     = busy_reg;

  // ***************************************************************
  // checks
  // ***************************************************************
  property p_run_count;
    @(posedge clk) disable iff (rst)
    (e_state_reg == sensor_pkg::E_IDLE && req_rise && !cfg_reg.ext_exp)
    |=> (frames_reg == $past(cfg_reg.frame_count));
  endproperty
  a_run_count: assert property (p_run_count) // [R1]
    else $error("frame count not loaded");

  property p_start_delay;
    @(posedge clk) disable iff (rst)
    (e_state_reg == sensor_pkg::E_DELAY && tick && e_cnt_reg == 24'h1)
    |=> (e_state_reg == sensor_pkg::E_EXPOSE
         && e_cnt_reg == cfg_reg.exp_time);
  endproperty
  a_start_delay: assert property (p_start_delay) // [R2]
    else $error("exposure start not after delay");

  property p_fot_to_read;
    @(posedge clk) disable iff (rst)
    (r_state_reg == sensor_pkg::R_FOT && tick && fot_cnt_reg == 16'h1
     && !handoff) |=> (r_state_reg == sensor_pkg::R_READ
                       && ro_left_reg == $past(ro_total));
  endproperty
  a_fot_to_read: assert property (p_fot_to_read) // [R4]
    else $error("readout did not follow overhead");

  property p_chain;
    @(posedge clk) disable iff (rst)
    (e_state_reg == sensor_pkg::E_DONE && r_state_reg == sensor_pkg::R_IDLE)
    |=> (r_state_reg == sensor_pkg::R_FOT && fot_cnt_reg == $past(fot_total));
  endproperty
  a_chain: assert property (p_chain) // [R6]
    else $error("overhead not started after readout");

  property p_abort;
    @(posedge clk) disable iff (rst)
    (cfg_reg.later_rev && r_state_reg == sensor_pkg::R_READ)
    |=> (r_state_reg != sensor_pkg::R_FOT);
  endproperty
  a_abort: assert property (p_abort) // [R9]
    else $error("readout aborted in later revision");

  property p_ext_stop;
    @(posedge clk) disable iff (rst)
    (cfg_reg.ext_exp && e_state_reg == sensor_pkg::E_EXPOSE && req_rise)
    |=> (e_state_reg == sensor_pkg::E_DONE);
  endproperty
  a_ext_stop: assert property (p_ext_stop) // [R11]
    else $error("external exposure did not stop");

  property p_first_bit;
    @(posedge clk) disable iff (rst)
    tick |=> (lvds_reg.forwarded_ddr_clock
              && lvds_reg.ctrl == $past(pix_valid)) ##1
             !lvds_reg.forwarded_ddr_clock;
  endproperty
  a_first_bit: assert property (p_first_bit) // [R17]
    else $error("first bit not in clock high phase");

  property p_word_len;
    @(posedge clk) disable iff (rst)
    (tick && !cfg_reg.bits12 && !cfg_write)
    |=> (bit_cnt_reg == 4'h9) ##8 (bit_cnt_reg == 4'h1)
        ##1 (bit_cnt_reg == 4'h0);
  endproperty
  a_word_len: assert property (p_word_len) // [R18]
    else $error("10-bit word length wrong");

  property p_burst_gap;
    @(posedge clk) disable iff (rst)
    (r_state_reg == sensor_pkg::R_READ && tick && !handoff
     && pix_reg == sensor_pkg::BURST_LEN) |=> (pix_reg == 8'h0);
  endproperty
  a_burst_gap: assert property (p_burst_gap) // [R19]
    else $error("burst gap not one period");

  property p_fold;
    @(posedge clk) disable iff (rst)
    cfg_reg.bits12 |-> (n_bursts == (cfg_reg.two_lane ? 4'h8 : 4'h4));
  endproperty
  a_fold: assert property (p_fold) // [R22]
    else $error("12-bit lane folding wrong");

endmodule // frame_request_exposure_readout

// File: logic/pixel_fifo.sv
// pixel fifo: parameterised buffer with valid and ready on both sides
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             rdy_reg, rdy_next, val_reg, val_next;
  logic             push, pop;

  // ***************************************************************
  // pointers and fill level
  // ***************************************************************
  always_comb begin
    push     = in_valid & rdy_reg;
    pop      = val_reg & out_ready;
    wr_next  = push ? wr_reg + 1'b1 : wr_reg;
    rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // flags registered so the ready pin comes straight from a flop
    rdy_next = cnt_next != (AW+1)'(DEPTH);
    val_next = cnt_next != '0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b0;
      val_reg <= 1'b0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
      val_reg <= val_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  assign in_ready  = rdy_reg;
  assign out_valid = val_reg;
  assign out_data  = mem[rd_reg];

endmodule // pixel_fifo

// File: logic/sensor_pkg.sv
// package: constants, types and carriers of the frame sequencer and serialiser
//
// Functional notes
// [R1] frame request starts run of count frames
// [R2] exposure starts 133 master cycles after request
// [R3] internal exposure length from exposure time setting
// [R4] exposure end enters overhead, then readout follows
// [R5] next frame exposes during previous readout
// [R6] next overhead starts right after previous readout
// [R7] host waits for overhead end before request
// [R8] later revision delays exposure to meet readout end
// [R9] earlier revision starts at once, aborts readout
// [R10] host spaces requests by overhead plus readout
// [R11] external mode: pin starts, request ends exposure
// [R12] host keeps exposure pin to request spacing
// [R13] exposure pulse accepted during or after readout
// [R14] sixteen data lanes, control lane, clock lane
// [R15] forwarded clock is ddr, half bit rate
// [R16] control words match pixel width, lane aligned
// [R17] lsb first, first bit in clock high
// [R18] one pixel word fills one master period; code sends a word in 10 or 12 clk cycles, then the lanes idle
// [R19] bursts of 128 pixels, one gap period
// [R20] sixteen lanes move a row in one slot
// [R21] fewer lanes: n bursts plus n gaps
// [R22] 12-bit forces four lanes, two-lane option
// [R23] overhead length setting resets to ten
// [R24] control bits flag pixel, row, frame valid
// [R25] pins sampled on clock before any use
// [R26] unused lanes send zeros, stay word aligned
package sensor_pkg;

  // ***************************************************************
  // sizes, counts and reset values
  // ***************************************************************
  localparam int          LANES           = 16;
  localparam int          WORD_MAX        = 12;
  localparam int          FIFO_DEPTH      = 32;
  localparam logic [7:0]  EXP_START_DELAY = 8'h85;
  localparam logic [7:0]  FOT_UNIT        = 8'h81;
  localparam logic [7:0]  BURST_LEN       = 8'h80;
  localparam logic [3:0]  BITS_WIDE       = 4'hC;
  localparam logic [3:0]  BITS_NARROW     = 4'hA;
  localparam logic [15:0] FRAME_COUNT_RST = 16'h0001;
  localparam logic [7:0]  FOT_LEN_RST     = 8'h0A;
  localparam logic [23:0] EXP_TIME_RST    = 24'h000400;
  localparam logic [10:0] ROWS_RST        = 11'h440;

  // control word bit positions
  localparam int CTL_PIXEL_VALID = 0;
  localparam int CTL_ROW_VALID   = 1;
  localparam int CTL_FRAME_VALID = 2;
  localparam int CTL_SLOT        = 3;
  localparam int CTL_FOT         = 5;
  localparam int CTL_INTE        = 6;
  localparam int CTL_ONE         = 9;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [2:0] {
    E_IDLE   = 3'h0,
    E_DELAY  = 3'h1,
    E_EXPOSE = 3'h3,
    E_DONE   = 3'h2,
    E_PEND   = 3'h6
  } expo_state_t;

  typedef enum logic [1:0] {
    R_IDLE = 2'h0,
    R_FOT  = 2'h1,
    R_READ = 2'h3
  } read_state_t;

  typedef struct packed {
    logic [15:0] frame_count;
    logic [23:0] exp_time;
    logic [7:0]  fot_len;
    logic [10:0] rows;
    logic [1:0]  lane_mode;
    logic        bits12;
    logic        two_lane;
    logic        ext_exp;
    logic        later_rev;
  } cfg_t;

  localparam cfg_t CFG_RST = '{FRAME_COUNT_RST, EXP_TIME_RST, FOT_LEN_RST,
                               ROWS_RST, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1};

  typedef struct packed {
    logic [LANES-1:0][WORD_MAX-1:0] word;
  } pix_bundle_t;

  typedef struct packed {
    logic [LANES-1:0] lanes;
    logic             ctrl;
    logic             forwarded_ddr_clock;
  } lvds_t;

endpackage

// File: verif/lane_receiver.sv
// receiver model: deserialises the lane 0 and lane 1 words and the control words
`timescale 1ns/1ps
module lane_receiver (
  input  wire logic              clk,
  input  wire sensor_pkg::lvds_t lvds,
  input  wire logic [3:0]        bits,
  output logic                   word_valid,
  output logic                   ddr_ok,
  output logic [11:0]            ctrl_word,
  output logic [11:0]            lane0_word,
  output logic [11:0]            lane1_word
);
  logic [3:0] cnt = 4'h0;
  initial ddr_ok = 1'b1;
  // a word starts only on a high clock lane after the idle gap
  always @(posedge clk) begin
    word_valid <= 1'b0;
    if (cnt != 4'h0 || lvds.forwarded_ddr_clock === 1'b1) begin
      ctrl_word[cnt]  <= lvds.ctrl;
      lane0_word[cnt] <= lvds.lanes[0];
      lane1_word[cnt] <= lvds.lanes[1];
      if (lvds.forwarded_ddr_clock !== ~cnt[0]) ddr_ok <= 1'b0;
      word_valid <= (cnt + 4'h1 == bits);
      cnt <= (cnt + 4'h1 == bits) ? 4'h0 : cnt + 4'h1;
    end
  end
endmodule // lane_receiver

// File: verif/tb.sv
// testbench: frame runs checked against a queue model of the pixel stream
`timescale 1ns/1ps
module tb;
  `define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
    fail_count++; $display("unexpected %s exp %0h got %0h", nm, ex, gt); end end
  logic clk = 0, rst = 1, frame_req_pin = 0, external_exposure_in = 0;
  logic master_clk_pin = 0, cfg_write = 0, pix_in_valid = 0;
  logic pix_in_ready, busy, word_valid, ddr_ok;
  logic [11:0] ctrl_word, lane0_word, lane1_word;
  logic [9:0] px_exp;
  sensor_pkg::cfg_t        cfg_in = sensor_pkg::CFG_RST;
  sensor_pkg::pix_bundle_t pix_in_data = '0;
  sensor_pkg::lvds_t       lvds_out;
  int fail_count = 0, comparisons = 0, pix_n, fot_n, pushed;
  logic [9:0] exp_q[$];
  always #4 clk = ~clk;
  // link clock free running, unrelated to clk
  always #62.5 master_clk_pin = ~master_clk_pin;
  frame_request_exposure_readout i_dut (.clk(clk), .rst(rst),
    .frame_req_pin(frame_req_pin), .external_exposure_in(external_exposure_in),
    .master_clk_pin(master_clk_pin), .cfg_in(cfg_in), .cfg_write(cfg_write),
    .pix_in_valid(pix_in_valid), .pix_in_data(pix_in_data),
    .pix_in_ready(pix_in_ready), .lvds_out(lvds_out), .busy(busy));
  lane_receiver i_rx (.clk(clk), .lvds(lvds_out), .bits(4'hA),
    .word_valid(word_valid), .ddr_ok(ddr_ok), .ctrl_word(ctrl_word),
    .lane0_word(lane0_word), .lane1_word(lane1_word));
  // ***************************************************************
  // word checks against the queue model
  // ***************************************************************
  always @(posedge clk) if (word_valid) begin
    `CHK("ctrl one bit", 1'b1, ctrl_word[9])
    if (ctrl_word[5] === 1'b1) fot_n++;
    if (ctrl_word[0] === 1'b1) begin
      pix_n++;
      px_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3FF;
      `CHK("lane0 word", px_exp, lane0_word[9:0])
      if (cfg_in.lane_mode == 2'h1)
        `CHK("idle lane", 10'h000, lane1_word[9:0])
    end
  end
  task automatic new_data;
    for (int i = 0; i < 16; i++) pix_in_data.word[i] = 12'($urandom);
  endtask
  // data only changes after a handshake or while valid is low
  task automatic push(input int n, input bit stall);
    int t;
    bit hs;
    t = 0;
    while (pushed < n && t < 100000) begin
      @(posedge clk);
      t++;
      // handshake seen at the edge, data moved only after it
      hs = pix_in_valid && pix_in_ready;
      #1;
      if (hs) begin
        exp_q.push_back(pix_in_data.word[0][9:0]);
        pushed++;
        new_data();
      end
      pix_in_valid = (pushed < n) && (!stall || $urandom_range(3) != 0);
    end
    `CHK("push wait", 1'b1, pushed == n)
  endtask
  task automatic run_test(input logic [1:0] mode, input logic [15:0] frames,
                          input bit ext);
    int n, t;
    n = 256 * (1 << mode) * frames;
    pushed = 0;
    pix_n = 0;
    fot_n = 0;
    #1 cfg_in.frame_count = frames;
    cfg_in.exp_time = 24'h000004;
    cfg_in.fot_len = 8'h01;
    cfg_in.rows = 11'h002;
    cfg_in.lane_mode = mode;
    cfg_in.ext_exp = ext;
    cfg_write = 1;
    @(posedge clk);
    #1 cfg_write = 0;
    push(32, 0);
    repeat (2) @(posedge clk);
    `CHK("fifo full", 1'b0, pix_in_ready)
    if (ext) begin
      #1 external_exposure_in = 1;
      repeat (4) @(posedge clk);
      #1 external_exposure_in = 0;
      repeat (20) @(posedge clk);
    end
    #1 frame_req_pin = 1;
    repeat (4) @(posedge clk);
    #1 frame_req_pin = 0;
    push(n, 1);
    t = 0;
    while (busy !== 1'b0 && t < 50000) begin
      @(posedge clk);
      t++;
    end
    `CHK("busy wait", 1'b1, t < 50000)
    repeat (20) @(posedge clk);
    `CHK("pixel words", n, pix_n)
    `CHK("overhead ticks", frames * (1 + 2 * (1 << mode)) * 129,
         fot_n)
    `CHK("queue drained", 0, exp_q.size())
    `CHK("ddr clock", 1'b1, ddr_ok)
    $display("test lane_mode %0d frames %0d done", mode, frames);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #640000;
    fail_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(89));
    new_data();
    repeat (5) @(posedge clk);
    `CHK("lanes in reset", '0, lvds_out)
    #1 rst = 0;
    @(posedge clk);
    #1;
    `CHK("ready after reset", 1'b1, pix_in_ready)
    run_test(2'h0, 16'h0001, 1'b0);
    run_test(2'h1, 16'h0002, 1'b0);
    run_test(2'h0, 16'h0001, 1'b1);
    wrap_up();
  end
endmodule // tb
